//--- rtl/mrs_pkg.sv
// Constants and types shared by the reset and interrupt sequencer
package mrs_pkg;
    // Register word indices; byte address is four times the index
    localparam logic [5:0] IDX_PORT2_MODE = 6'h03;
    localparam logic [5:0] IDX_PORT3_DATA = 6'h06;
    localparam logic [5:0] IDX_PORT3_CSR = 6'h0F;
    localparam logic [5:0] IDX_RAM_CTRL = 6'h14;
    localparam logic [5:0] IDX_COND_MASK = 6'h20;
    localparam logic [5:0] IDX_SEQ_STATUS = 6'h21;
    // Field positions
    localparam int RAM_ENABLE_POS = 6;
    localparam int P3_FLAG_POS = 7;
    localparam int P3_ENABLE_POS = 6;
    localparam int P3_OSS_POS = 4;
    localparam int P3_LATCH_POS = 3;
    localparam int MODE_LSB_POS = 5;
    localparam int IMASK_POS = 4;
    // Reset values
    localparam logic RAM_ENABLE_RST = 1'b1;
    localparam logic [7:0] PORT3_CSR_RST = 8'h00;
    localparam logic [7:0] PORT3_CSR_WMASK = 8'h58;
    localparam logic [2:0] MODE_SINGLE_CHIP = 3'h7;
    // Timing counts
    localparam logic [1:0] RESET_ADDR_HIGH_CYCLE = 2'h3;
    // Vector pairs, high byte at the even address
    localparam logic [15:0] VEC_RESET = 16'hFFFE;
    localparam logic [15:0] VEC_TRAP = 16'hFFEE;
    localparam logic [15:0] VEC_NMI = 16'hFFFC;
    localparam logic [15:0] VEC_SWI = 16'hFFFA;
    localparam logic [15:0] VEC_EXT = 16'hFFF8;
    localparam logic [15:0] VEC_CAPTURE = 16'hFFF6;
    localparam logic [15:0] VEC_COMPARE = 16'hFFF4;
    localparam logic [15:0] VEC_OVERFLOW = 16'hFFF2;
    localparam logic [15:0] VEC_SERIAL = 16'hFFF0;
    localparam logic [15:0] ADDR_ALL_HIGH = 16'hFFFF;
    // AXI responses
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    typedef enum logic [3:0] {
        SRC_NONE, SRC_RESET, SRC_TRAP, SRC_NMI, SRC_SWI,
        SRC_EXT, SRC_CAPTURE, SRC_COMPARE, SRC_OVERFLOW, SRC_SERIAL
    } mrs_src_t;
endpackage

//--- rtl/mrs_fall_detect.sv
// Falling edge detector for synchronous inputs
`timescale 1ns/1ps
`default_nettype none
module mrs_fall_detect #(
    parameter int WIDTH = 1
) (
    // Clock and reset
    input wire logic aclk,
    input wire logic rst,
    // Level in, edge out
    input wire logic [WIDTH-1:0] level_in,
    output logic [WIDTH-1:0] fall_out
);
    logic [WIDTH-1:0] prev_q;

    always_ff @(posedge aclk)
    begin
        if (rst)
        begin
            prev_q <= '1;
        end
        else
        begin
            prev_q <= level_in;
        end
    end

    assign fall_out = prev_q & ~level_in;
endmodule
`default_nettype wire

//--- rtl/mrs_vector_fetch.sv
// Two-byte vector fetch: high byte from even address, low from odd
`timescale 1ns/1ps
`default_nettype none
module mrs_vector_fetch (
    // Clock and reset
    input wire logic aclk,
    input wire logic rst,
    // Control
    input wire logic start,
    input wire logic [15:0] base_addr,
    output logic busy,
    output logic done,
    output logic [15:0] vector,
    // Memory read port
    output logic mem_rd,
    output logic [15:0] mem_addr,
    input wire logic [7:0] mem_rdata,
    input wire logic mem_ack
);
    typedef enum logic [1:0] {VF_IDLE, VF_HIGH, VF_LOW} mrs_vf_state_t;
    mrs_vf_state_t state_q;

    always_ff @(posedge aclk)
    begin
        if (rst)
        begin
            state_q <= VF_IDLE;
            mem_addr <= 16'h0000;
            vector <= 16'h0000;
            done <= 1'b0;
        end
        else
        begin
            done <= 1'b0;
            unique case (state_q)
                VF_IDLE:
                begin
                    if (start)
                    begin
                        mem_addr <= base_addr;
                        state_q <= VF_HIGH;
                    end
                end
                VF_HIGH:
                begin
                    if (mem_ack)
                    begin
                        vector[15:8] <= mem_rdata;
                        mem_addr <= base_addr | 16'h0001;
                        state_q <= VF_LOW;
                    end
                end
                VF_LOW:
                begin
                    if (mem_ack)
                    begin
                        vector[7:0] <= mem_rdata;
                        done <= 1'b1;
                        state_q <= VF_IDLE;
                    end
                end
            endcase
        end
    end

    assign mem_rd = state_q != VF_IDLE;
    assign busy = state_q != VF_IDLE;
endmodule
`default_nettype wire

//--- rtl/mrs_sequencer.sv
// Reset, standby and interrupt sequencer with AXI4-Lite registers
`timescale 1ns/1ps
`default_nettype none
module mrs_sequencer
    import mrs_pkg::*;
(
    // Clock and bus reset
    input wire logic aclk,
    input wire logic aresetn,
    // AXI4-Lite slave
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // Chip pins
    input wire logic chip_reset_n,
    input wire logic standby_request_n,
    input wire logic nmi_request_n,
    input wire logic external_maskable_request_n,
    input wire logic port3_input_strobe,
    input wire logic [2:0] port2_mode_pins,
    // Core handshake
    input wire logic instr_done,
    input wire logic e_phase,
    input wire logic trap_error,
    input wire logic software_exception,
    output logic stack_req,
    input wire logic stack_done,
    output logic [15:0] pc_value,
    output logic pc_load,
    // Internal peripheral events
    input wire logic capture_event,
    input wire logic compare_event,
    input wire logic counter_overflow_event,
    input wire logic receive_full_flag,
    input wire logic overrun_framing_flag,
    input wire logic transmit_empty_flag,
    output logic internal_maskable_request,
    // Memory and address bus
    output logic mem_rd,
    output logic [15:0] address_bus,
    input wire logic [7:0] mem_rdata,
    input wire logic mem_ack,
    // Power and mode
    output logic oscillator_stop,
    output logic clock_freeze,
    output logic ram_enable,
    output logic [2:0] mode_latch
);
    typedef enum logic [2:0] {
        ST_RESET, ST_BOOT, ST_RUN, ST_ALIGN, ST_STACK, ST_FETCH
    } mrs_state_t;

    logic int_rst;
    logic chip_rst;
    mrs_state_t state_q;
    mrs_src_t src_q;
    mrs_src_t pick;
    logic [1:0] rst_cnt_q;
    logic chip_reset_n_q;
    logic imask_q;
    logic nmi_pend_q;
    logic trap_pend_q;
    logic swi_pend_q;
    logic ram_enable_q;
    logic [2:0] mode_q;
    logic [7:0] p3_csr_q;
    logic p3_flag_q;
    logic p3_armed_q;
    logic [7:0] p3_data_q;
    logic [1:0] falls;
    logic ext_req;
    logic serial_req;
    logic vf_start;
    logic vf_busy;
    logic vf_done;
    logic [15:0] vf_vector;
    logic [15:0] vf_addr;
    logic [15:0] vf_base;
    logic wr_go;
    logic rd_go;
    logic [5:0] wr_idx;
    logic [5:0] rd_idx;
    logic wr_hit;
    logic rd_hit;
    logic p3_data_access;
    logic [7:0] rd_byte;

    // Standby forces the sequencer into reset; RAM control and AXI responses are kept, the mode latch reloads from the straps while chip_reset_n is high
    assign int_rst = !aresetn || !standby_request_n;
    assign oscillator_stop = !standby_request_n;
    assign clock_freeze = !standby_request_n;
    assign chip_rst = int_rst || !chip_reset_n;

    mrs_fall_detect #(
        .WIDTH(2)
    ) u_falls (
        .aclk(aclk),
        .rst(int_rst),
        .level_in({port3_input_strobe, nmi_request_n}),
        .fall_out(falls)
    );

    mrs_vector_fetch u_fetch (
        .aclk(aclk),
        .rst(chip_rst),
        .start(vf_start),
        .base_addr(vf_base),
        .busy(vf_busy),
        .done(vf_done),
        .vector(vf_vector),
        .mem_rd(mem_rd),
        .mem_addr(vf_addr),
        .mem_rdata(mem_rdata),
        .mem_ack(mem_ack)
    );

    // Request sources
    assign serial_req = receive_full_flag || overrun_framing_flag || transmit_empty_flag;
    assign internal_maskable_request = capture_event || compare_event
        || counter_overflow_event || serial_req;
    assign ext_req = !external_maskable_request_n
        || (p3_flag_q && p3_csr_q[P3_ENABLE_POS]);

    // Fixed priority selection
    always_comb
    begin
        pick = SRC_NONE;
        if (trap_pend_q)
        begin
            pick = SRC_TRAP;
        end
        else if (nmi_pend_q)
        begin
            pick = SRC_NMI;
        end
        else if (swi_pend_q)
        begin
            pick = SRC_SWI;
        end
        else if (!imask_q)
        begin
            if (ext_req)
            begin
                pick = SRC_EXT;
            end
            else if (capture_event)
            begin
                pick = SRC_CAPTURE;
            end
            else if (compare_event)
            begin
                pick = SRC_COMPARE;
            end
            else if (counter_overflow_event)
            begin
                pick = SRC_OVERFLOW;
            end
            else if (serial_req)
            begin
                pick = SRC_SERIAL;
            end
        end
    end

    // Vector base for the selected source
    always_comb
    begin
        unique case (src_q)
            SRC_TRAP: vf_base = VEC_TRAP;
            SRC_NMI: vf_base = VEC_NMI;
            SRC_SWI: vf_base = VEC_SWI;
            SRC_EXT: vf_base = VEC_EXT;
            SRC_CAPTURE: vf_base = VEC_CAPTURE;
            SRC_COMPARE: vf_base = VEC_COMPARE;
            SRC_OVERFLOW: vf_base = VEC_OVERFLOW;
            SRC_SERIAL: vf_base = VEC_SERIAL;
            default: vf_base = VEC_RESET;
        endcase
    end

    // Reset cycle counter and release detection
    always_ff @(posedge aclk)
    begin
        if (int_rst)
        begin
            rst_cnt_q <= 2'h0;
            chip_reset_n_q <= 1'b0;
        end
        else
        begin
            chip_reset_n_q <= chip_reset_n;
            if (chip_reset_n)
            begin
                rst_cnt_q <= 2'h0;
            end
            else if (rst_cnt_q != RESET_ADDR_HIGH_CYCLE)
            begin
                rst_cnt_q <= rst_cnt_q + 2'h1;
            end
        end
    end

    // Mode straps caught at the release edge
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            mode_q <= 3'h0;
        end
        else if (chip_reset_n && !chip_reset_n_q)
        begin
            mode_q <= port2_mode_pins;
        end
    end

    // Main sequence
    always_ff @(posedge aclk)
    begin
        if (chip_rst)
        begin
            state_q <= ST_RESET;
            src_q <= SRC_RESET;
        end
        else
        begin
            unique case (state_q)
                ST_RESET:
                begin
                    src_q <= SRC_RESET;
                    state_q <= ST_BOOT;
                end
                ST_BOOT:
                begin
                    if (vf_done)
                    begin
                        state_q <= ST_RUN;
                    end
                end
                ST_RUN:
                begin
                    if (instr_done && pick != SRC_NONE)
                    begin
                        src_q <= pick;
                        state_q <= ST_ALIGN;
                    end
                end
                ST_ALIGN:
                begin
                    if (e_phase)
                    begin
                        state_q <= ST_STACK;
                    end
                end
                ST_STACK:
                begin
                    if (stack_done)
                    begin
                        state_q <= ST_FETCH;
                    end
                end
                ST_FETCH:
                begin
                    if (vf_done)
                    begin
                        state_q <= ST_RUN;
                    end
                end
            endcase
        end
    end

    assign vf_start = (state_q == ST_RESET)
        || (state_q == ST_STACK && stack_done);
    assign stack_req = state_q == ST_STACK;
    assign address_bus = (!chip_reset_n && rst_cnt_q == RESET_ADDR_HIGH_CYCLE)
        ? ADDR_ALL_HIGH : vf_addr;

    // Program counter load from fetched vector
    always_ff @(posedge aclk)
    begin
        if (chip_rst)
        begin
            pc_value <= 16'h0000;
            pc_load <= 1'b0;
        end
        else
        begin
            pc_load <= vf_done;
            if (vf_done)
            begin
                pc_value <= vf_vector;
            end
        end
    end

    // Pending edge and exception requests; a new event beats the take
    always_ff @(posedge aclk)
    begin
        if (chip_rst)
        begin
            nmi_pend_q <= 1'b0;
            trap_pend_q <= 1'b0;
            swi_pend_q <= 1'b0;
        end
        else
        begin
            if (falls[0])
            begin
                nmi_pend_q <= 1'b1;
            end
            else if (state_q == ST_RUN && instr_done && pick == SRC_NMI)
            begin
                nmi_pend_q <= 1'b0;
            end
            if (trap_error)
            begin
                trap_pend_q <= 1'b1;
            end
            else if (state_q == ST_RUN && instr_done && pick == SRC_TRAP)
            begin
                trap_pend_q <= 1'b0;
            end
            if (software_exception)
            begin
                swi_pend_q <= 1'b1;
            end
            else if (state_q == ST_RUN && instr_done && pick == SRC_SWI)
            begin
                swi_pend_q <= 1'b0;
            end
        end
    end

    // AXI4-Lite handshakes
    assign wr_go = s_axi_awvalid && s_axi_wvalid && !s_axi_bvalid;
    assign s_axi_awready = wr_go;
    assign s_axi_wready = wr_go;
    assign rd_go = s_axi_arvalid && !s_axi_rvalid;
    assign s_axi_arready = rd_go;
    assign wr_idx = s_axi_awaddr[7:2];
    assign rd_idx = s_axi_araddr[7:2];
    assign wr_hit = wr_idx == IDX_PORT2_MODE || wr_idx == IDX_PORT3_DATA
        || wr_idx == IDX_PORT3_CSR || wr_idx == IDX_RAM_CTRL
        || wr_idx == IDX_COND_MASK || wr_idx == IDX_SEQ_STATUS;
    assign p3_data_access = (wr_go && wr_idx == IDX_PORT3_DATA)
        || (rd_go && rd_idx == IDX_PORT3_DATA);

    // Interrupt mask bit
    always_ff @(posedge aclk)
    begin
        if (chip_rst)
        begin
            imask_q <= 1'b1;
        end
        else if (state_q == ST_STACK && stack_done && src_q >= SRC_EXT)
        begin
            imask_q <= 1'b1;
        end
        else if (wr_go && wr_idx == IDX_COND_MASK && s_axi_wstrb[0])
        begin
            imask_q <= s_axi_wdata[IMASK_POS];
        end
    end

    // RAM control, kept across standby so retention survives
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            ram_enable_q <= RAM_ENABLE_RST;
        end
        else if (wr_go && wr_idx == IDX_RAM_CTRL && s_axi_wstrb[0])
        begin
            ram_enable_q <= s_axi_wdata[RAM_ENABLE_POS];
        end
    end

    // Port 3 control, data and strobe flag
    always_ff @(posedge aclk)
    begin
        if (chip_rst)
        begin
            p3_csr_q <= PORT3_CSR_RST;
            p3_flag_q <= 1'b0;
            p3_armed_q <= 1'b0;
            p3_data_q <= 8'h00;
        end
        else
        begin
            if (wr_go && wr_idx == IDX_PORT3_CSR && s_axi_wstrb[0])
            begin
                p3_csr_q <= s_axi_wdata[7:0] & PORT3_CSR_WMASK;
            end
            if (wr_go && wr_idx == IDX_PORT3_DATA && s_axi_wstrb[0])
            begin
                p3_data_q <= s_axi_wdata[7:0];
            end
            if (falls[1] && mode_q == MODE_SINGLE_CHIP)
            begin
                p3_flag_q <= 1'b1;
            end
            else if (p3_armed_q && p3_data_access)
            begin
                p3_flag_q <= 1'b0;
            end
            if (rd_go && rd_idx == IDX_PORT3_CSR && p3_flag_q)
            begin
                p3_armed_q <= 1'b1;
            end
            else if (p3_data_access)
            begin
                p3_armed_q <= 1'b0;
            end
        end
    end

    // Read data selection
    always_comb
    begin
        rd_byte = 8'h00;
        rd_hit = 1'b1;
        unique case (rd_idx)
            IDX_PORT2_MODE: rd_byte = {mode_q, 5'h00};
            IDX_PORT3_DATA: rd_byte = p3_data_q;
            IDX_PORT3_CSR: rd_byte = p3_csr_q | {p3_flag_q, 7'h00};
            IDX_RAM_CTRL: rd_byte = {1'b0, ram_enable_q, 6'h00};
            IDX_COND_MASK: rd_byte = {3'h0, imask_q, 4'h0};
            IDX_SEQ_STATUS: rd_byte = {1'b0, state_q, src_q};
            default: rd_hit = 1'b0;
        endcase
    end

    // Write response
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= RESP_OKAY;
        end
        else if (wr_go)
        begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= wr_hit ? RESP_OKAY : RESP_SLVERR;
        end
        else if (s_axi_bready)
        begin
            s_axi_bvalid <= 1'b0;
        end
    end

    // Read response
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h00000000;
            s_axi_rresp <= RESP_OKAY;
        end
        else if (rd_go)
        begin
            s_axi_rvalid <= 1'b1;
            s_axi_rdata <= {24'h000000, rd_byte};
            s_axi_rresp <= rd_hit ? RESP_OKAY : RESP_SLVERR;
        end
        else if (s_axi_rready)
        begin
            s_axi_rvalid <= 1'b0;
        end
    end

    assign ram_enable = ram_enable_q;
    assign mode_latch = mode_q;
endmodule
`default_nettype wire

//--- tb/mrs_sequencer_assertions.sv
// Concurrent checks on the sequencer ports
`timescale 1ns/1ps
`default_nettype none
module mrs_sequencer_assertions (
    // Clock and resets
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic chip_reset_n,
    input wire logic standby_request_n,
    // Observed pins
    input wire logic [2:0] port2_mode_pins,
    input wire logic stack_req,
    input wire logic pc_load,
    input wire logic mem_rd,
    input wire logic mem_ack,
    input wire logic [15:0] address_bus,
    input wire logic oscillator_stop,
    input wire logic clock_freeze,
    input wire logic [2:0] mode_latch
);
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    property p_standby_request_n;
        !standby_request_n |-> oscillator_stop && clock_freeze;
    endproperty
    a_standby_request_n: assert property (p_standby_request_n) else $error("clock runs in standby");
    property p_rst_addr;
        (!chip_reset_n && standby_request_n)[*4] |-> address_bus == 16'hFFFF;
    endproperty
    a_rst_addr: assert property (p_rst_addr) else $error("address not high");
    property p_mode;
        $rose(chip_reset_n) |=> mode_latch == $past(port2_mode_pins);
    endproperty
    a_mode: assert property (p_mode) else $error("straps not latched");
    property p_pc_pulse;
        pc_load |=> !pc_load;
    endproperty
    a_pc_pulse: assert property (p_pc_pulse) else $error("long load pulse");
    property p_stack_first;
        stack_req |-> !mem_rd;
    endproperty
    a_stack_first: assert property (p_stack_first) else $error("fetch while stacking");
    property p_vec_range;
        mem_rd && chip_reset_n |-> address_bus >= 16'hFFEE;
    endproperty
    a_vec_range: assert property (p_vec_range) else $error("fetch outside table");
    property p_pc_after_ack;
        pc_load |-> $past(mem_ack, 2);
    endproperty
    a_pc_after_ack: assert property (p_pc_after_ack) else $error("load without byte");
    property p_odd_next;
        mem_rd && mem_ack && !address_bus[0] |=> address_bus == $past(address_bus) + 16'h1;
    endproperty
    a_odd_next: assert property (p_odd_next) else $error("odd byte not next");
endmodule
`default_nettype wire

//--- tb/mrs_partner.sv
// Far side: vector memory and core stacking
`timescale 1ns/1ps
`default_nettype none
module mrs_partner (
    // Clock and wait states
    input wire logic aclk,
    input wire logic [1:0] delay,
    // Memory and stacking
    input wire logic mem_rd,
    input wire logic [15:0] address_bus,
    output logic [7:0] mem_rdata,
    output logic mem_ack,
    input wire logic stack_req,
    output logic stack_done
);
    logic [1:0] cnt_q;
    logic want;
    assign want = (mem_rd && !mem_ack) || (stack_req && !stack_done);
    always_ff @(posedge aclk)
    begin
        mem_ack <= 1'b0;
        stack_done <= 1'b0;
        mem_rdata <= ~mem_rdata;
        cnt_q <= want ? cnt_q + 2'h1 : 2'h0;
        if (want && cnt_q == delay)
        begin
            cnt_q <= 2'h0;
            mem_ack <= mem_rd;
            stack_done <= stack_req && !mem_rd;
            mem_rdata <= address_bus[0] ? ~address_bus[7:0] : address_bus[7:0];
        end
    end
endmodule
`default_nettype wire

//--- tb/tb_top.sv
// Testbench for the reset and interrupt sequencer
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin n_checks++; if ((a) !== (b)) begin n_errors++; $display("[FAIL] %0t %h %h", $time, a, b); end end
module tb_top;
    import mrs_pkg::*;
    logic aclk = 0, aresetn = 0, awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
    logic awready, wready, bvalid, arready, rvalid, stk, stk_done, pc_load, mem_rd, mem_ack;
    logic osc_stop, clk_frz, ram_en, imr, chip_n = 0, standby_request_n_n = 1, nmi_n = 1, ext_n = 1;
    logic strobe = 1, idone = 0, e_ph = 0;
    logic [1:0] bresp, rresp, resp_q, pls = 0, dly = 0;
    logic [2:0] straps = 3'h5, mode;
    logic [3:0] wstrb = 4'hF;
    logic [5:0] iev = 0;
    logic [7:0] awaddr = 0, araddr = 0, mdata;
    logic [15:0] pc, abus, vt [6];
    logic [31:0] wdata = 0, rdata, rd_q;
    int n_errors = 0, n_checks = 0;
    mrs_sequencer u_mrs_sequencer (.aclk(aclk), .aresetn(aresetn),
        .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
        .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
        .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
        .chip_reset_n(chip_n), .standby_request_n(standby_request_n_n), .nmi_request_n(nmi_n),
        .external_maskable_request_n(ext_n), .port3_input_strobe(strobe),
        .port2_mode_pins(straps), .instr_done(idone), .e_phase(e_ph), .trap_error(pls[1]),
        .software_exception(pls[0]), .stack_req(stk), .stack_done(stk_done), .pc_value(pc),
        .pc_load(pc_load), .capture_event(iev[0]), .compare_event(iev[1]),
        .counter_overflow_event(iev[2]), .receive_full_flag(iev[3]),
        .overrun_framing_flag(iev[4]), .transmit_empty_flag(iev[5]),
        .internal_maskable_request(imr), .mem_rd(mem_rd), .address_bus(abus),
        .mem_rdata(mdata), .mem_ack(mem_ack), .oscillator_stop(osc_stop),
        .clock_freeze(clk_frz), .ram_enable(ram_en), .mode_latch(mode));
    mrs_partner u_mrs_partner (.aclk(aclk), .delay(dly), .mem_rd(mem_rd), .address_bus(abus),
        .mem_rdata(mdata), .mem_ack(mem_ack), .stack_req(stk), .stack_done(stk_done));
    initial forever #25 aclk = ~aclk;
    always @(posedge aclk) e_ph <= ~e_ph;
    task automatic wrap_up;
        if (n_errors == 0 && n_checks > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask
    task automatic xf(input logic w, input logic [5:0] i, input logic [7:0] d);
        @(posedge aclk);
        {awaddr, araddr} <= {2{i, 2'b00}};
        wdata <= {24'h0, d};
        {awvalid, wvalid, bready} <= {3{w}};
        {arvalid, rready} <= {2{!w}};
        do
        begin
            @(posedge aclk);
            if (awready) awvalid <= 0;
            if (wready) wvalid <= 0;
            if (arready) arvalid <= 0;
        end
        while (!(bvalid || rvalid));
        {bready, rready} <= 0;
        rd_q = rdata;
        resp_q = w ? bresp : rresp;
    endtask
    task automatic wpc(input logic [15:0] v);
        do
        begin
            @(posedge aclk);
        end
        while (pc_load !== 1'b1);
        `CHK(pc, {v[7:0], ~(v[7:0] + 8'h01)})
    endtask
    task automatic svc(input logic [1:0] p, input logic [15:0] v);
        @(posedge aclk);
        pls <= p;
        @(posedge aclk);
        pls <= 0;
        idone <= 1;
        @(posedge aclk);
        idone <= 0;
        wpc(v);
    endtask
    task automatic chip_rst(input logic [2:0] m);
        @(posedge aclk);
        chip_n <= 0;
        straps <= m;
        repeat (5) @(posedge aclk);
        `CHK(abus, ADDR_ALL_HIGH)
        chip_n <= 1;
        wpc(VEC_RESET);
        `CHK(mode, m)
        xf(0, IDX_COND_MASK, 0);
        `CHK(rd_q[IMASK_POS], 1'b1)
    endtask
    initial
    begin
        vt = '{VEC_CAPTURE, VEC_COMPARE, VEC_OVERFLOW, VEC_SERIAL, VEC_SERIAL, VEC_SERIAL};
        repeat (20) @(posedge aclk);
        aresetn <= 1;
        chip_rst(3'h5);
        xf(0, IDX_PORT2_MODE, 0);
        `CHK(rd_q[7:5], 3'h5)
        xf(0, 6'h3F, 0);
        `CHK(resp_q, RESP_SLVERR)
        ext_n <= 0;
        @(posedge aclk) idone <= 1;
        @(posedge aclk) idone <= 0;
        repeat (10) @(posedge aclk);
        `CHK(stk, 1'b0)
        xf(1, IDX_COND_MASK, 0);
        iev <= 6'h01;
        svc(0, VEC_EXT);
        ext_n <= 1;
        xf(0, IDX_COND_MASK, 0);
        `CHK(rd_q[IMASK_POS], 1'b1)
        dly <= 3;
        for (int i = 0; i < 6; i++)
        begin
            iev <= 6'h01 << i;
            xf(1, IDX_COND_MASK, 0);
            `CHK(imr, 1'b1)
            svc(0, vt[i]);
        end
        iev <= 0;
        nmi_n <= 0;
        svc(2'b11, VEC_TRAP);
        nmi_n <= 1;
        svc(0, VEC_NMI);
        svc(0, VEC_SWI);
        xf(1, IDX_RAM_CTRL, 0);
        `CHK(ram_en, 1'b0)
        standby_request_n_n <= 0;
        repeat (3) @(posedge aclk);
        `CHK({osc_stop, clk_frz}, 2'b11)
        standby_request_n_n <= 1;
        `CHK(ram_en, 1'b0)
        chip_rst(MODE_SINGLE_CHIP);
        xf(1, IDX_PORT3_CSR, 8'h40);
        strobe <= 0;
        repeat (3) @(posedge aclk);
        xf(0, IDX_PORT3_DATA, 0);
        xf(0, IDX_PORT3_CSR, 0);
        `CHK(rd_q[7:0], 8'hC0)
        strobe <= 1;
        xf(1, IDX_COND_MASK, 0);
        svc(0, VEC_EXT);
        xf(0, IDX_PORT3_DATA, 0);
        xf(0, IDX_PORT3_CSR, 0);
        `CHK(rd_q[7:0], 8'h40)
        wrap_up;
    end
    initial
    begin
        repeat (20000) @(posedge aclk);
        n_errors++;
        wrap_up;
    end
endmodule
bind mrs_sequencer mrs_sequencer_assertions u_mrs_sequencer_assertions (.aclk(aclk),
    .aresetn(aresetn), .chip_reset_n(chip_reset_n), .standby_request_n(standby_request_n),
    .port2_mode_pins(port2_mode_pins), .stack_req(stack_req), .pc_load(pc_load),
    .mem_rd(mem_rd), .mem_ack(mem_ack), .address_bus(address_bus),
    .oscillator_stop(oscillator_stop), .clock_freeze(clock_freeze), .mode_latch(mode_latch));
`default_nettype wire
